// [design/acs_cfg.svh]
// constants of the converter control sequencer
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_ADDR_CTRL 4'h0
`define ACS_ADDR_RESULT 4'h1
`define ACS_ADDR_STAT 4'h2
`define ACS_ADDR_CLR 4'h3
`define ACS_ADDR_IEN 4'h4
`define ACS_ADDR_AUTO 4'h5
`define ACS_CTRL_MASK 16'ha7f6
`define ACS_BIT_ON 15
`define ACS_BIT_SIDL 13
`define ACS_BIT_RES 10
`define ACS_BIT_FORM 8
`define ACS_BIT_SRC 4
`define ACS_BIT_AUTO_SAMPLE 2
`define ACS_BIT_SAMPLE_ENABLE 1
`define ACS_BIT_DONE 0
`define ACS_CONV_CYC_10 8'h0c
`define ACS_CONV_CYC_12 8'h0e
`define ACS_AUTO_RST 8'h1f
`endif

// [design/acs_pkg.sv]
// types of the converter control sequencer
package acs_pkg;
   typedef enum logic [3:0] {
      ACS_SRC_SW = 4'h0,
      ACS_SRC_TMR3 = 4'h2,
      ACS_SRC_TMR5 = 4'h3,
      ACS_SRC_CTU = 4'h4,
      ACS_SRC_TMR1 = 4'h5,
      ACS_SRC_AUTO = 4'h7
   } acs_src_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } acs_bus_t;
   typedef struct packed {
      logic tmr1;
      logic tmr3;
      logic tmr5;
      logic ctu;
   } acs_trig_t;
endpackage

// [design/acs_format.sv]
// result formatter for the converter
`timescale 1ns/100ps
module acs_format
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // raw result
   input wire logic load_i,
   input wire logic res12_i,
   input wire logic [1:0] form_i,
   input wire logic [11:0] raw_i,
   // formatted result
   output logic [15:0] result_o
);
   logic [15:0] next_result;
   logic [15:0] result;
   logic [11:0] code;
   logic [11:0] offs;
   always_comb
   begin
      code = res12_i ? raw_i : {2'h0, raw_i[9:0]};
      offs = res12_i ? (code ^ 12'h800) : (code ^ 12'h200);
      next_result = result;
      if (load_i)
      begin
         case (form_i)
            2'h3:
               next_result = res12_i ? {offs, 4'h0} : {offs[9:0], 6'h00};
            2'h1:
               next_result = res12_i ? {{4{offs[11]}}, offs} : {{6{offs[9]}}, offs[9:0]};
            2'h2:
               next_result = res12_i ? {code, 4'h0} : {code[9:0], 6'h00};
            default:
               next_result = {4'h0, code};
         endcase
      end
   end
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         result <= 16'h0000;
      else
         result <= next_result;
   end
   assign result_o = result;
endmodule

// [design/acs_top.sv]
// converter control sequencer with register port
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "acs_cfg.svh"
module acs_top
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // register port
   input wire acs_pkg::acs_bus_t bus_i,
   output logic [15:0] rdata_o,
   // device state and trigger events
   input wire logic idle_i,
   input wire acs_pkg::acs_trig_t trig_i,
   // converter core
   input wire logic [11:0] conv_data_i,
   output logic powered_o,
   output logic sampling_o,
   output logic converting_o,
   output logic res12_o,
   // interrupt
   output logic irq_o
);
   import acs_pkg::*;
   logic [15:0] ctrl;
   logic [15:0] next_ctrl;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [7:0] auto_cyc;
   logic [7:0] next_auto_cyc;
   logic busy;
   logic next_busy;
   logic [1:0] sts;
   logic [1:0] next_sts;
   logic [1:0] ien;
   logic [1:0] next_ien;
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   logic [15:0] result;
   logic [3:0] tsync1;
   logic [3:0] tsync2;
   logic [3:0] tsync3;
   logic [3:0] tedge;
   logic [3:0] tlvl;
   logic [3:0] next_tlvl;
   logic run;
   logic trig;
   logic done_ev;
   logic sw_trig;
   logic wr_ctrl;
   acs_src_t src;

   // event synchronisers, edge once second and third stages agree
   // agreed level moves only on a match, so a one-cycle glitch never counts
   always_comb
   begin
      next_tlvl = (tsync2 & tsync3) | (tlvl & (tsync2 | tsync3));
   end
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         tsync1 <= 4'h0;
         tsync2 <= 4'h0;
         tsync3 <= 4'h0;
         tlvl <= 4'h0;
      end
      else
      begin
         tsync1 <= {trig_i.tmr1, trig_i.tmr3, trig_i.tmr5, trig_i.ctu};
         tsync2 <= tsync1;
         tsync3 <= tsync2;
         tlvl <= next_tlvl;
      end
   end
   assign tedge = tsync2 & tsync3 & ~tlvl;

   assign wr_ctrl = bus_i.wr && (bus_i.addr == `ACS_ADDR_CTRL);
   assign run = ctrl[`ACS_BIT_ON] && !(ctrl[`ACS_BIT_SIDL] && idle_i);
   assign src = acs_src_t'(ctrl[`ACS_BIT_SRC +: 4]);
   assign sw_trig = wr_ctrl && ctrl[`ACS_BIT_SAMPLE_ENABLE] && !bus_i.wdata[`ACS_BIT_SAMPLE_ENABLE];

   // trigger selection ends sampling
   always_comb
   begin
      trig = 1'b0;
      case (src)
         ACS_SRC_SW: trig = sw_trig;
         ACS_SRC_TMR1: trig = tedge[3];
         ACS_SRC_TMR3: trig = tedge[2];
         ACS_SRC_TMR5: trig = tedge[1];
         ACS_SRC_CTU: trig = tedge[0];
         ACS_SRC_AUTO: trig = (cnt == auto_cyc);
         default: trig = 1'b0;
      endcase
      trig = trig && run && ctrl[`ACS_BIT_SAMPLE_ENABLE] && !busy;
   end
   assign done_ev = busy && run && (cnt == 8'h01);

   // sequencer state and control register
   always_comb
   begin
      next_ctrl = ctrl;
      next_cnt = cnt;
      next_busy = busy;
      next_auto_cyc = auto_cyc;
      if (wr_ctrl)
         next_ctrl = (bus_i.wdata & `ACS_CTRL_MASK) | (ctrl & 16'h0001);
      if (bus_i.wr && (bus_i.addr == `ACS_ADDR_AUTO))
         next_auto_cyc = bus_i.wdata[7:0];
      if (!run)
      begin
         next_busy = 1'b0;
         next_cnt = 8'h00;
      end
      else if (trig)
      begin
         next_busy = 1'b1;
         next_ctrl[`ACS_BIT_SAMPLE_ENABLE] = 1'b0;
         next_ctrl[`ACS_BIT_DONE] = 1'b0;
         next_cnt = ctrl[`ACS_BIT_RES] ? `ACS_CONV_CYC_12 : `ACS_CONV_CYC_10;
      end
      else if (busy)
      begin
         next_ctrl[`ACS_BIT_SAMPLE_ENABLE] = 1'b0;
         if (done_ev)
         begin
            next_busy = 1'b0;
            next_cnt = 8'h00;
            next_ctrl[`ACS_BIT_DONE] = 1'b1;
            if (ctrl[`ACS_BIT_AUTO_SAMPLE])
               next_ctrl[`ACS_BIT_SAMPLE_ENABLE] = 1'b1;
         end
         else
            next_cnt = cnt - 8'h01;
      end
      else if (ctrl[`ACS_BIT_SAMPLE_ENABLE] && (src == ACS_SRC_AUTO))
         next_cnt = cnt + 8'h01;
      else
         next_cnt = 8'h00;
      if (trig && !busy)
         next_cnt = ctrl[`ACS_BIT_RES] ? `ACS_CONV_CYC_12 : `ACS_CONV_CYC_10;
   end
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         ctrl <= 16'h0000;
         cnt <= 8'h00;
         busy <= 1'b0;
         auto_cyc <= `ACS_AUTO_RST;
      end
      else
      begin
         ctrl <= next_ctrl;
         cnt <= next_cnt;
         busy <= next_busy;
         auto_cyc <= next_auto_cyc;
      end
   end

   // interrupt status: bit0 conversion done, bit1 trigger taken
   always_comb
   begin
      next_sts = sts;
      next_ien = ien;
      if (bus_i.wr && (bus_i.addr == `ACS_ADDR_CLR))
         next_sts = sts & ~bus_i.wdata[1:0];
      if (bus_i.wr && (bus_i.addr == `ACS_ADDR_IEN))
         next_ien = bus_i.wdata[1:0];
      next_sts = next_sts | {trig, done_ev};
   end
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         sts <= 2'h0;
         ien <= 2'h0;
      end
      else
      begin
         sts <= next_sts;
         ien <= next_ien;
      end
   end

   // read port, data one cycle after the strobe
   always_comb
   begin
      next_rdata = 16'h0000;
      if (bus_i.rd)
      begin
         if (bus_i.addr == `ACS_ADDR_CTRL)
            next_rdata = ctrl;
         else if (bus_i.addr == `ACS_ADDR_RESULT)
            next_rdata = result;
         else if (bus_i.addr == `ACS_ADDR_STAT)
            next_rdata = {14'h0000, sts};
         else if (bus_i.addr == `ACS_ADDR_IEN)
            next_rdata = {14'h0000, ien};
         else if (bus_i.addr == `ACS_ADDR_AUTO)
            next_rdata = {8'h00, auto_cyc};
         else
            next_rdata = 16'h0000;
      end
   end
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         rdata <= 16'h0000;
      else
         rdata <= next_rdata;
   end

   acs_format u_format
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .load_i(done_ev),
      .res12_i(ctrl[`ACS_BIT_RES]),
      .form_i(ctrl[`ACS_BIT_FORM +: 2]),
      .raw_i(conv_data_i),
      .result_o(result)
   );

   assign rdata_o = rdata;
   assign powered_o = ctrl[`ACS_BIT_ON];
   assign sampling_o = ctrl[`ACS_BIT_SAMPLE_ENABLE] && run;
   assign converting_o = busy;
   assign res12_o = ctrl[`ACS_BIT_RES];
   assign irq_o = |(sts & ien);

   property p_off_idle;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !ctrl[`ACS_BIT_ON] |=> !busy;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("busy while disabled");

   property p_idle_stop;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ctrl[`ACS_BIT_SIDL] && idle_i) |=> !busy;
   endproperty
   a_idle_stop: assert property (p_idle_stop) else $error("ran in idle");

   sequence s_start;
      trig && !ctrl[`ACS_BIT_RES];
   endsequence
   property p_len10;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_start ##1 (run && !ctrl[`ACS_BIT_RES]) [*8] |-> busy;
   endproperty
   a_len10: assert property (p_len10) else $error("conversion too short");

   property p_trig_clr;
      @(posedge mclk_i) disable iff (!rst_n_i)
      trig |=> busy && !ctrl[`ACS_BIT_SAMPLE_ENABLE] && !ctrl[`ACS_BIT_DONE];
   endproperty
   a_trig_clr: assert property (p_trig_clr) else $error("trigger did not clear");

   property p_done;
      @(posedge mclk_i) disable iff (!rst_n_i)
      done_ev |=> ctrl[`ACS_BIT_DONE] && !busy;
   endproperty
   a_done: assert property (p_done) else $error("done not set");

   property p_busy_nodone;
      @(posedge mclk_i) disable iff (!rst_n_i)
      busy |-> !ctrl[`ACS_BIT_DONE];
   endproperty
   a_busy_nodone: assert property (p_busy_nodone) else $error("done while busy");

   property p_auto_sample;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (done_ev && ctrl[`ACS_BIT_AUTO_SAMPLE]) |=> ctrl[`ACS_BIT_SAMPLE_ENABLE];
   endproperty
   a_auto_sample: assert property (p_auto_sample) else $error("no auto sample");

   property p_sw;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (src == ACS_SRC_SW && sw_trig && run && !busy) |=> busy;
   endproperty
   a_sw: assert property (p_sw) else $error("software trigger lost");

   property p_tmr1;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (src == ACS_SRC_TMR1 && tedge[3] && run && ctrl[`ACS_BIT_SAMPLE_ENABLE] && !busy) |=> busy;
   endproperty
   a_tmr1: assert property (p_tmr1) else $error("timer trigger lost");

   property p_ctu;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (src == ACS_SRC_CTU && tedge[0] && run && ctrl[`ACS_BIT_SAMPLE_ENABLE] && !busy) |=> busy;
   endproperty
   a_ctu: assert property (p_ctu) else $error("charge unit trigger lost");

   property p_auto;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (src == ACS_SRC_AUTO && cnt == auto_cyc && run && ctrl[`ACS_BIT_SAMPLE_ENABLE] && !busy) |=> busy;
   endproperty
   a_auto: assert property (p_auto) else $error("auto convert lost");

   property p_unimpl;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ctrl & ~`ACS_CTRL_MASK & 16'hfffe) == 16'h0000;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
endmodule

// [dv/tb_top.sv]
// self-checking bench of the converter control sequencer
`timescale 1ns/100ps
`include "acs_cfg.svh"
`define CHK(nm, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
         mismatches++; \
      end \
   end
module tb_top;
   import acs_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic idle = 1'b0;
   logic [11:0] conv_data = 12'h000;
   acs_bus_t bus = '0;
   acs_trig_t trig = '0;
   logic [15:0] rdata_o;
   logic powered_o, sampling_o, converting_o, res12_o, irq_o;
   int mismatches = 0;
   int cmp_count = 0;
   logic [15:0] s = 16'h0063;
   logic [15:0] q;
   logic [3:0] codes [4] = '{4'h5, 4'h2, 4'h3, 4'h4};
   logic [3:0] bits [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
   always #2 mclk_i = ~mclk_i;
   acs_top uut
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .bus_i(bus),
      .rdata_o(rdata_o),
      .idle_i(idle),
      .trig_i(trig),
      .conv_data_i(conv_data),
      .powered_o(powered_o),
      .sampling_o(sampling_o),
      .converting_o(converting_o),
      .res12_o(res12_o),
      .irq_o(irq_o)
   );
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // signed codes flip the top bit, then justify left or extend the sign
   function automatic logic [15:0] fmt_exp(input logic [11:0] d, input logic r12,
                                           input logic [1:0] f);
      int w;
      logic [15:0] v;
      w = r12 ? 12 : 10;
      v = r12 ? {4'h0, d} : {6'h00, d[9:0]};
      if (f[0])
         v[w-1] = ~v[w-1];
      if (f[1])
         v = v << (16 - w);
      else if (f[0] && v[w-1])
         v = v | (16'hffff << w);
      return v;
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk_i);
      bus <= '0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge mclk_i);
      bus <= '0;
      #1;
      d = rdata_o;
   endtask
   // bounded wait on busy (sel 0) or sampling (sel 1)
   task automatic wait_sig(input int sel, input logic lvl);
      int n;
      n = 0;
      while (((sel == 0) ? converting_o : sampling_o) !== lvl)
      begin
         @(posedge mclk_i);
         #1;
         n++;
         if (n > 300)
         begin
            $display("[FAIL] wait expected %h seen timeout", lvl);
            mismatches++;
            wrap_up();
         end
      end
   endtask
   task automatic run_sw(input logic r12, input logic [1:0] f, input logic [11:0] d);
      logic [15:0] c;
      logic [7:0] n;
      c = 16'h8000 | (16'(r12) << 10) | (16'(f) << 8);
      @(posedge mclk_i);
      conv_data <= d;
      wr(`ACS_ADDR_CTRL, c | 16'h0002);
      `CHK("sampling", 1'b1, sampling_o)
      wr(`ACS_ADDR_CTRL, c);
      `CHK("converting", 1'b1, converting_o)
      `CHK("holding", 1'b0, sampling_o)
      rd(`ACS_ADDR_CTRL, q);
      `CHK("ctrl low bits", 2'b00, q[1:0])
      n = 8'h02;
      while (converting_o === 1'b1 && n < 8'h3c)
      begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      `CHK("conv cycles", r12 ? `ACS_CONV_CYC_12 : `ACS_CONV_CYC_10, n)
      rd(`ACS_ADDR_CTRL, q);
      `CHK("done", 1'b1, q[0])
      rd(`ACS_ADDR_RESULT, q);
      `CHK("result", fmt_exp(d, r12, f), q)
      `CHK("irq set", 1'b1, irq_o)
      wr(`ACS_ADDR_CLR, 16'h0003);
      `CHK("irq clear", 1'b0, irq_o)
   endtask
   initial
   begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(`ACS_ADDR_CTRL, q);
      `CHK("ctrl reset", 16'h0000, q)
      `CHK("powered reset", 1'b0, powered_o)
      wr(`ACS_ADDR_IEN, 16'h0001);
      wr(`ACS_ADDR_CTRL, 16'h5809);
      rd(`ACS_ADDR_CTRL, q);
      `CHK("unimpl bits", 16'h0000, q)
      repeat (6)
      begin
         s = lfsr(s);
         wr(`ACS_ADDR_CTRL, s & 16'hff7f);
         rd(`ACS_ADDR_CTRL, q);
         `CHK("ctrl rw", s & 16'h2776, q)
         `CHK("res12", s[10], res12_o)
         `CHK("off", 1'b0, powered_o)
      end
      wr(4'hf, 16'hffff);
      rd(4'hf, q);
      `CHK("unmapped", 16'h0000, q)
      for (int f = 0; f < 4; f++)
         for (int r = 0; r < 2; r++)
         begin
            s = lfsr(s);
            run_sw(r[0], f[1:0], s[11:0]);
         end
      run_sw(1'b1, 2'b01, 12'h800);
      run_sw(1'b0, 2'b11, 12'h1ff);
      // each trigger source (three timers and the CTU) ignores the next source's event and answers its own
      for (int i = 0; i < 4; i++)
      begin
         wr(`ACS_ADDR_CTRL, 16'h8002 | (16'(codes[i]) << 4));
         @(posedge mclk_i);
         trig <= bits[(i + 1) % 4];
         repeat (8) @(posedge mclk_i);
         trig <= '0;
         #1;
         `CHK("foreign trig", 1'b0, converting_o)
         @(posedge mclk_i);
         trig <= bits[i];
         wait_sig(0, 1'b1);
         `CHK("trig holds", 1'b0, sampling_o)
         @(posedge mclk_i);
         trig <= '0;
         wait_sig(0, 1'b0);
         `CHK("trig irq", 1'b1, irq_o)
         wr(`ACS_ADDR_CLR, 16'h0003);
      end
      wr(`ACS_ADDR_IEN, 16'h0000);
      wr(`ACS_ADDR_AUTO, 16'h0003);
      wr(`ACS_ADDR_CTRL, 16'h8076);
      wait_sig(0, 1'b1);
      wait_sig(0, 1'b0);
      wait_sig(1, 1'b1);
      wait_sig(0, 1'b1);
      rd(`ACS_ADDR_STAT, q);
      `CHK("masked irq", 1'b0, irq_o)
      `CHK("status", 1'b1, q[0])
      wr(`ACS_ADDR_CTRL, 16'h8072);
      wait_sig(0, 1'b1);
      wait_sig(0, 1'b0);
      repeat (5) @(posedge mclk_i);
      #1;
      `CHK("no restart", 1'b0, sampling_o)
      @(posedge mclk_i);
      idle <= 1'b1;
      wr(`ACS_ADDR_CTRL, 16'ha002);
      `CHK("idle stop", 1'b0, sampling_o)
      wr(`ACS_ADDR_CTRL, 16'h8002);
      `CHK("idle run", 1'b1, sampling_o)
      @(posedge mclk_i);
      idle <= 1'b0;
      wr(`ACS_ADDR_CTRL, 16'h0002);
      `CHK("disabled", 1'b0, sampling_o)
      `CHK("powered", 1'b0, powered_o)
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(`ACS_ADDR_CTRL, q);
      `CHK("ctrl rereset", 16'h0000, q)
      wrap_up();
   end
endmodule
